// *** core/ues_cfg.svh ***
// command codes, field positions, reset values and counts of the status command block
`ifndef UES_CFG_SVH
`define UES_CFG_SVH

`define UES_CMD_READ_FLAGS   8'hF4
`define UES_CMD_SELECT_BASE  8'h00
`define UES_CMD_LAST_BASE    8'h40
`define UES_NUM_EP           6
`define UES_FLAG_BUS_RESET   6
`define UES_FLAG_SUSPEND     7
`define UES_FLAGS_RESET      8'h00
`define UES_STAT_RESET       8'h00
`define UES_STAT_OK          0
`define UES_STAT_ERR_LSB     1
`define UES_STAT_SETUP       5
`define UES_STAT_TOGGLE      6
`define UES_STAT_OVERRUN     7
`define UES_SEL_FULL         0
`define UES_SEL_STALL        1
`define UES_MISSED_SOF_LIMIT 2'h3
// positions inside the synchronised pin vector
`define UES_PIN_WR           0
`define UES_PIN_RD           1
`define UES_PIN_CS           2
`define UES_PIN_A0           3
`define UES_PIN_EOT          4
`define UES_PIN_W            13

`endif

// *** core/ues_pkg.sv ***
// types shared by the status command block
package ues_pkg;
    typedef enum logic [1:0] {
        UES_RSP_NONE   = 2'b00,
        UES_RSP_FLAGS  = 2'b01,
        UES_RSP_SELECT = 2'b10,
        UES_RSP_LAST   = 2'b11
    } ues_rsp_t;
endpackage

// *** core/ues_stat_mem.sv ***
// small per-endpoint memory for last-transaction status words
`timescale 1ns/1ps
module ues_stat_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 6,
    parameter int AW    = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata_q
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rdata_d;

    initial begin
        if (DEPTH > (1 << AW) || DEPTH < 1) begin
            $error("ues_stat_mem: DEPTH does not fit AW");
        end
    end

    // out-of-range read gives zero rather than garbage
    always_comb begin
        rdata_d = '0;
        if (int'(raddr) < DEPTH) begin
            rdata_d = mem_q[raddr];
        end
    end

    // words start cleared so a status read before any transfer shows zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            rdata_q <= '0;
        end else begin
            if (we && int'(waddr) < DEPTH) begin
                mem_q[waddr] <= wdata;
            end
            rdata_q <= rdata_d;
        end
    end
endmodule

// *** core/ues_status_cmd.sv ***
// status and event reporting command interpreter behind the 8-bit parallel bus
// Summary of operation
// - low flag bits 0..5 mark events of endpoint indexes 0..5, zero at reset
// - endpoint flag survives flag reads, clears only on its last-status command write
// - low flag bit 6 marks bus reset, clears after flag register read
// - low flag bit 7 marks suspend entry after three missed frames, and exit
// - high flag bit 0 marks end of dma, clears when read; others reserved
// - command equal to endpoint index selects it; status read is optional
// - select status bit 0 reads one when the endpoint buffer holds data
// - select status bit 1 reads one when the endpoint is stalled
// - command 40h plus index returns that endpoint's last-transaction status
// - status bit 0 reads one when the last transfer succeeded
// - status bits 4..1 carry the four-bit transfer error code
// - status bit 5 reads one when the last packet carried a setup token
// - status bit 6 gives data toggle, zero data0, one data1
// - status bit 7 marks that an unread status was overwritten
// - interrupt output asserts while any flag bit is set
// - end-of-transfer pin ends dma, clears dma enable and raises dma flag
`timescale 1ns/1ps
`include "ues_cfg.svh"
module ues_status_cmd #(
    parameter int NUM_EP = `UES_NUM_EP
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] bus_data_in,
    output logic      [7:0] bus_data_out,
    output logic            bus_data_oe_n,
    input  wire logic       bus_a0,
    input  wire logic       bus_cs_n,
    input  wire logic       bus_rd_n,
    input  wire logic       bus_wr_n,
    output logic            int_n,
    input  wire logic       int_pin_mode_sof,
    input  wire logic [5:0] ep_full,
    input  wire logic [5:0] ep_stall,
    input  wire logic       xfer_done,
    input  wire logic [2:0] xfer_ep,
    input  wire logic       xfer_ok,
    input  wire logic [3:0] xfer_err,
    input  wire logic       xfer_setup,
    input  wire logic       xfer_toggle,
    input  wire logic       usb_bus_reset,
    input  wire logic       frame_tick,
    input  wire logic       sof_seen,
    output logic            usb_suspended,
    input  wire logic       dma_start,
    input  wire logic       transfer_end_in_n,
    output logic            dma_enable
);
    import ues_pkg::*;

    initial begin
        if (NUM_EP != `UES_NUM_EP) begin
            $error("ues_status_cmd: only six endpoint indexes are served");
        end
    end

    // pins and their synchronisers
    logic [`UES_PIN_W-1:0] sync1_q, sync2_q, prev_q;
    logic [`UES_PIN_W-1:0] pins;
    logic                  cs_act, wr_rise, rd_fall, rd_rise, eot_fall;
    logic [7:0]            cmd_byte;

    // control state
    ues_rsp_t   kind_q, kind_d;
    logic [2:0] ep_sel_q, ep_sel_d;
    logic       idx_q, idx_d;
    logic [7:0] flags_q, flags_d;
    logic       dma_flag_q, dma_flag_d;
    logic [5:0] unread_q, unread_d;
    logic [1:0] miss_q, miss_d;
    logic       susp_q, susp_d;
    logic       sof_hit_q, sof_hit_d;
    logic       dma_en_q, dma_en_d;
    logic [7:0] dout_q, dout_d;
    logic       oe_n_q, oe_n_d;
    logic       int_n_q, int_n_d;
    logic [5:0] last_clr;
    logic [7:0] stat_wdata, stat_rdata;

    function automatic logic [5:0] ep_onehot(input logic [2:0] ep);
        logic [5:0] v;
        v = '0;
        if (int'(ep) < `UES_NUM_EP) begin
            v[ep] = 1'b1;
        end
        return v;
    endfunction

    assign pins = {bus_data_in, transfer_end_in_n, bus_a0, bus_cs_n, bus_rd_n, bus_wr_n};

    // two flops on every pin, edges judged on the second only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= {8'h00, 5'h1F};
            sync2_q <= {8'h00, 5'h1F};
            prev_q  <= {8'h00, 5'h1F};
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign cs_act   = ~sync2_q[`UES_PIN_CS];
    assign wr_rise  = cs_act & sync2_q[`UES_PIN_WR] & ~prev_q[`UES_PIN_WR];
    assign rd_fall  = cs_act & ~sync2_q[`UES_PIN_RD] & prev_q[`UES_PIN_RD];
    assign rd_rise  = sync2_q[`UES_PIN_RD] & ~prev_q[`UES_PIN_RD];
    assign eot_fall = ~sync2_q[`UES_PIN_EOT] & prev_q[`UES_PIN_EOT];
    // data taken at the end of the write strobe, when it has long settled
    assign cmd_byte = sync2_q[`UES_PIN_W-1:`UES_PIN_W-8];

    // status word: overrun bit tracks a still-unread previous word
    assign stat_wdata = {unread_q[xfer_ep], xfer_toggle, xfer_setup, xfer_err, xfer_ok};

    ues_stat_mem #(
        .WIDTH (8),
        .DEPTH (`UES_NUM_EP),
        .AW    (3)
    ) u_stat_mem (
        .clk     (clk),
        .rst_n   (rst_n),
        .we      (xfer_done),
        .waddr   (xfer_ep),
        .wdata   (stat_wdata),
        .raddr   (ep_sel_q),
        .rdata_q (stat_rdata)
    );

    // command decode, flags, suspend tracking, dma and the read port
    always_comb begin
        kind_d     = kind_q;
        ep_sel_d   = ep_sel_q;
        idx_d      = idx_q;
        flags_d    = flags_q;
        dma_flag_d = dma_flag_q;
        unread_d   = unread_q;
        miss_d     = miss_q;
        susp_d     = susp_q;
        sof_hit_d  = sof_hit_q;
        dma_en_d   = dma_en_q;
        dout_d     = dout_q;
        oe_n_d     = oe_n_q;
        last_clr   = '0;

        // a0 high marks a command; data writes are not used by these commands
        if (wr_rise && sync2_q[`UES_PIN_A0]) begin
            idx_d = 1'b0;
            if (cmd_byte == `UES_CMD_READ_FLAGS) begin
                kind_d = UES_RSP_FLAGS;
            end else if (cmd_byte < `UES_CMD_SELECT_BASE + 8'(`UES_NUM_EP)) begin
                kind_d   = UES_RSP_SELECT;
                ep_sel_d = cmd_byte[2:0];
            end else if (cmd_byte >= `UES_CMD_LAST_BASE &&
                         cmd_byte < `UES_CMD_LAST_BASE + 8'(`UES_NUM_EP)) begin
                kind_d   = UES_RSP_LAST;
                ep_sel_d = cmd_byte[2:0];
                last_clr = ep_onehot(cmd_byte[2:0]);
            end else begin
                kind_d = UES_RSP_NONE;
            end
        end

        // last-status command write clears the flag and the unread mark; a new event wins
        flags_d[5:0] = flags_q[5:0] & ~last_clr;
        unread_d     = unread_q & ~last_clr;

        // read strobe: present the byte while low, release on rise
        if (rd_fall && !sync2_q[`UES_PIN_A0]) begin
            oe_n_d = 1'b0;
            case (kind_q)
                UES_RSP_FLAGS: begin
                    if (!idx_q) begin
                        dout_d = flags_q;
                        flags_d[`UES_FLAG_BUS_RESET] = 1'b0;
                        flags_d[`UES_FLAG_SUSPEND]   = 1'b0;
                    end else begin
                        dout_d     = {7'h00, dma_flag_q};
                        dma_flag_d = 1'b0;
                    end
                end
                UES_RSP_SELECT: begin
                    dout_d = {6'h00, ep_stall[ep_sel_q], ep_full[ep_sel_q]};
                end
                UES_RSP_LAST: begin
                    dout_d = stat_rdata;
                end
                default: begin
                    dout_d = 8'h00;
                end
            endcase
        end else if (rd_rise || !cs_act) begin
            oe_n_d = 1'b1;
            if (rd_rise && !oe_n_q) begin
                idx_d = 1'b1;
            end
        end

        // frame counting; a frame with any sof resets the miss count
        if (frame_tick) begin
            if (sof_hit_q || sof_seen) begin
                miss_d = 2'h0;
            end else if (miss_q != `UES_MISSED_SOF_LIMIT) begin
                miss_d = miss_q + 2'h1;
            end
            sof_hit_d = 1'b0;
        end else if (sof_seen) begin
            sof_hit_d = 1'b1;
        end
        if (!susp_q && frame_tick && !(sof_hit_q || sof_seen) &&
            miss_q == `UES_MISSED_SOF_LIMIT - 2'h1) begin
            susp_d = 1'b1;
            flags_d[`UES_FLAG_SUSPEND] = 1'b1;
        end else if (susp_q && sof_seen) begin
            susp_d = 1'b0;
            miss_d = 2'h0;
            flags_d[`UES_FLAG_SUSPEND] = 1'b1;
        end

        // hardware events are applied last so set beats clear
        if (usb_bus_reset) begin
            flags_d[`UES_FLAG_BUS_RESET] = 1'b1;
        end
        if (xfer_done) begin
            flags_d[5:0] = flags_d[5:0] | ep_onehot(xfer_ep);
            unread_d     = unread_d | ep_onehot(xfer_ep);
        end

        // end of transfer stops dma only if it was already enabled; a start from idle in that cycle survives
        if (dma_start) begin
            dma_en_d = 1'b1;
        end
        if (eot_fall && dma_en_q) begin
            dma_en_d   = 1'b0;
            dma_flag_d = 1'b1;
        end

        // int follows the registered flags, so it drops one cycle after them
        int_n_d = ~((|flags_q) | dma_flag_q | (int_pin_mode_sof & sof_seen));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kind_q     <= UES_RSP_NONE;
            ep_sel_q   <= 3'h0;
            idx_q      <= 1'b0;
            flags_q    <= `UES_FLAGS_RESET;
            dma_flag_q <= 1'b0;
            unread_q   <= 6'h00;
            miss_q     <= 2'h0;
            susp_q     <= 1'b0;
            sof_hit_q  <= 1'b0;
            dma_en_q   <= 1'b0;
            dout_q     <= 8'h00;
            oe_n_q     <= 1'b1;
            int_n_q    <= 1'b1;
        end else begin
            kind_q     <= kind_d;
            ep_sel_q   <= ep_sel_d;
            idx_q      <= idx_d;
            flags_q    <= flags_d;
            dma_flag_q <= dma_flag_d;
            unread_q   <= unread_d;
            miss_q     <= miss_d;
            susp_q     <= susp_d;
            sof_hit_q  <= sof_hit_d;
            dma_en_q   <= dma_en_d;
            dout_q     <= dout_d;
            oe_n_q     <= oe_n_d;
            int_n_q    <= int_n_d;
        end
    end

    assign bus_data_out  = dout_q;
    assign bus_data_oe_n = oe_n_q;
    assign int_n         = int_n_q;
    assign usb_suspended = susp_q;
    assign dma_enable    = dma_en_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_sel_read;
        rd_fall && !sync2_q[`UES_PIN_A0] && kind_q == UES_RSP_SELECT;
    endsequence
    sequence s_flag_first_read;
        rd_fall && !sync2_q[`UES_PIN_A0] && kind_q == UES_RSP_FLAGS && !idx_q;
    endsequence

    property p_ep_flag_set;
        xfer_done && xfer_ep < 3'h6 |=> flags_q[$past(xfer_ep)];
    endproperty
    a_ep_flag_set: assert property (p_ep_flag_set) else $error("endpoint flag not set");

    property p_ep_flag_hold;
        s_flag_first_read and flags_q[0] |=> flags_q[0];
    endproperty
    a_ep_flag_hold: assert property (p_ep_flag_hold) else $error("endpoint flag lost on read");

    property p_bus_reset_clear;
        s_flag_first_read and !usb_bus_reset |=> !flags_q[`UES_FLAG_BUS_RESET] && !oe_n_q;
    endproperty
    a_bus_reset_clear: assert property (p_bus_reset_clear) else $error("bus reset flag kept");

    property p_suspend_enter;
        frame_tick && !sof_seen && !sof_hit_q && !susp_q && miss_q == 2'h2
            |=> susp_q && flags_q[`UES_FLAG_SUSPEND];
    endproperty
    a_suspend_enter: assert property (p_suspend_enter) else $error("suspend entry missed");

    property p_sel_byte;
        s_sel_read |=> bus_data_out == {6'h00, $past(ep_stall[ep_sel_q]), $past(ep_full[ep_sel_q])};
    endproperty
    a_sel_byte: assert property (p_sel_byte) else $error("select status byte wrong");

    property p_dma_end;
        eot_fall && dma_en_q |=> !dma_en_q && dma_flag_q;
    endproperty
    a_dma_end: assert property (p_dma_end) else $error("dma end not handled");

    property p_int_on;
        (|flags_q) |=> !int_n;
    endproperty
    a_int_on: assert property (p_int_on) else $error("interrupt not asserted");

    property p_int_off;
        !(|flags_q) && !dma_flag_q && !(int_pin_mode_sof && sof_seen) |=> int_n;
    endproperty
    a_int_off: assert property (p_int_off) else $error("interrupt not released");
endmodule

// *** tb/ues_mcu_model.sv ***
// bus master model of the microcontroller on the 8-bit command bus
`timescale 1ns/1ps
module ues_mcu_model (
    input  wire logic       clk,
    input  wire logic [7:0] dev_data,
    input  wire logic       dev_oe_n,
    output logic      [7:0] bus_data,
    output logic            a0,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n
);
    logic [7:0] mcu_d;
    logic       mcu_drv;
    logic [7:0] last_q;

    // resolved bus level; a floating bus shows the inverse of its last driven value, never a copy of it
    assign bus_data = mcu_drv ? mcu_d : (!dev_oe_n ? dev_data : ~last_q);

    always @(posedge clk) begin
        if (mcu_drv || !dev_oe_n)
            last_q <= bus_data;
    end

    initial begin
        mcu_d = 8'h00;
        mcu_drv = 1'b0;
        last_q = 8'h00;
        a0 = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // command cycle; data held from before the strobe until after it rises
    task automatic cmd(input logic [7:0] code);
        a0 = 1'b1;
        cs_n = 1'b0;
        mcu_d = code;
        mcu_drv = 1'b1;
        step(4);
        wr_n = 1'b0;
        step(4);
        wr_n = 1'b1;
        step(4);
        cs_n = 1'b1;
        mcu_drv = 1'b0;
        step(4);
    endtask

    // data read, taken while the strobe is still low, past the answer delay
    task automatic rd(output logic [7:0] d, output logic oe_n);
        a0 = 1'b0;
        cs_n = 1'b0;
        step(4);
        rd_n = 1'b0;
        step(6);
        d = bus_data;
        oe_n = dev_oe_n;
        rd_n = 1'b1;
        step(4);
        cs_n = 1'b1;
        step(4);
    endtask
endmodule

// *** tb/tb_ues_status_cmd.sv ***
// self-checking bench of the status command block driven through the controller model
`timescale 1ns/1ps
`include "ues_cfg.svh"
module tb_ues_status_cmd;
    logic       clk, rst_n, oe_n, a0, cs_n, rd_n, wr_n, int_n, xfer_done, xfer_ok, xfer_setup;
    logic       xfer_toggle, usb_bus_reset, frame_tick, sof_seen, usb_suspended, dma_start;
    logic       transfer_end_in_n, dma_enable, roe, int_pin_mode_sof;
    logic [7:0] bus_data, dout, rb;
    logic [5:0] ep_full, ep_stall;
    logic [3:0] xfer_err;
    logic [2:0] xfer_ep, ep;
    int         n_mismatch, check_count, cycles;
    logic [3:0] codes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                               4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hF};

    ues_status_cmd dut_u (.clk(clk), .rst_n(rst_n), .bus_data_in(bus_data),
        .bus_data_out(dout), .bus_data_oe_n(oe_n), .bus_a0(a0), .bus_cs_n(cs_n),
        .bus_rd_n(rd_n), .bus_wr_n(wr_n), .int_n(int_n), .int_pin_mode_sof(int_pin_mode_sof),
        .ep_full(ep_full), .ep_stall(ep_stall), .xfer_done(xfer_done), .xfer_ep(xfer_ep),
        .xfer_ok(xfer_ok), .xfer_err(xfer_err), .xfer_setup(xfer_setup),
        .xfer_toggle(xfer_toggle), .usb_bus_reset(usb_bus_reset), .frame_tick(frame_tick),
        .sof_seen(sof_seen), .usb_suspended(usb_suspended), .dma_start(dma_start),
        .transfer_end_in_n(transfer_end_in_n), .dma_enable(dma_enable));

    ues_mcu_model mcu_u (.clk(clk), .dev_data(dout), .dev_oe_n(oe_n), .bus_data(bus_data),
        .a0(a0), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));

    always #20 clk = ~clk;

    // hang guard, well above the roughly two thousand cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    // read one byte, check it was driven onto the bus and let go again afterwards
    task automatic rd_chk(input string what, input logic [7:0] exp);
        mcu_u.rd(rb, roe);
        chk_bit("drive enable", 1'b0, roe);
        chk_byte(what, exp, rb);
        chk_bit("drive release", 1'b1, oe_n);
    endtask

    task automatic xfer(input logic [2:0] e, input logic [3:0] err, input logic ok, su, tg);
        xfer_ep = e;
        xfer_err = err;
        xfer_ok = ok;
        xfer_setup = su;
        xfer_toggle = tg;
        xfer_done = 1'b1;
        step(1);
        xfer_done = 1'b0;
    endtask

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, n_mismatch);
    endtask

    initial begin
        {clk, rst_n, xfer_done, xfer_ok, xfer_setup, xfer_toggle} = '0;
        {usb_bus_reset, frame_tick, sof_seen, dma_start, xfer_err, xfer_ep} = '0;
        int_pin_mode_sof = 1'b0;
        transfer_end_in_n = 1'b1;
        ep_full = 6'h15;
        ep_stall = 6'h2A;
        n_mismatch = 0;
        check_count = 0;
        cycles = 0;
        step(5);
        rst_n = 1'b1;
        step(6);
        chk_bit("int_n", 1'b1, int_n);
        chk_bit("suspended", 1'b0, usb_suspended);
        chk_bit("dma_enable", 1'b0, dma_enable);
        mcu_u.cmd(`UES_CMD_READ_FLAGS);
        rd_chk("flags low", 8'h00);
        rd_chk("flags high", 8'h00);
        done("reset");
        // a select left without its optional read, then every index read back
        mcu_u.cmd(8'h02);
        for (int i = 0; i < 6; i++) begin
            mcu_u.cmd(8'(i));
            rd_chk("select", {6'h00, ep_stall[i], ep_full[i]});
        end
        // a code outside every command range answers a read with zero
        mcu_u.cmd(8'h10);
        rd_chk("unknown command", 8'h00);
        done("select");
        for (int k = 0; k < 13; k++) begin
            ep = 3'(k % 6);
            xfer(ep, codes[k], k[0], k[1], k[2]);
            step(2);
            chk_bit("int_n", 1'b0, int_n);
            mcu_u.cmd(`UES_CMD_READ_FLAGS);
            rd_chk("flags low", 8'(1 << ep));
            mcu_u.cmd(`UES_CMD_READ_FLAGS);
            rd_chk("flags low", 8'(1 << ep));
            mcu_u.cmd(8'h40 + ep);
            rd_chk("last status", {1'b0, k[2], k[1], codes[k], k[0]});
            chk_bit("int_n", 1'b1, int_n);
        end
        // second status lands before the first was read
        xfer(3'h2, 4'h0, 1'b1, 1'b0, 1'b1);
        step(1);
        xfer(3'h2, 4'h9, 1'b0, 1'b1, 1'b0);
        mcu_u.cmd(8'h42);
        rd_chk("last status", {1'b1, 1'b0, 1'b1, 4'h9, 1'b0});
        done("transfer status");
        usb_bus_reset = 1'b1;
        step(1);
        usb_bus_reset = 1'b0;
        step(2);
        chk_bit("int_n", 1'b0, int_n);
        mcu_u.cmd(`UES_CMD_READ_FLAGS);
        rd_chk("flags low", 8'h40);
        chk_bit("int_n", 1'b1, int_n);
        mcu_u.cmd(`UES_CMD_READ_FLAGS);
        rd_chk("flags low", 8'h00);
        done("bus reset");
        for (int t = 0; t < 3; t++) begin
            chk_bit("suspended", 1'b0, usb_suspended);
            frame_tick = 1'b1;
            step(1);
            frame_tick = 1'b0;
            step(3);
        end
        chk_bit("suspended", 1'b1, usb_suspended);
        mcu_u.cmd(`UES_CMD_READ_FLAGS);
        rd_chk("flags low", 8'h80);
        sof_seen = 1'b1;
        step(1);
        sof_seen = 1'b0;
        step(2);
        chk_bit("suspended", 1'b0, usb_suspended);
        mcu_u.cmd(`UES_CMD_READ_FLAGS);
        rd_chk("flags low", 8'h80);
        mcu_u.cmd(`UES_CMD_READ_FLAGS);
        rd_chk("flags low", 8'h00);
        done("suspend");
        dma_start = 1'b1;
        step(1);
        dma_start = 1'b0;
        step(2);
        chk_bit("dma_enable", 1'b1, dma_enable);
        transfer_end_in_n = 1'b0;
        step(6);
        transfer_end_in_n = 1'b1;
        chk_bit("dma_enable", 1'b0, dma_enable);
        chk_bit("int_n", 1'b0, int_n);
        mcu_u.cmd(`UES_CMD_READ_FLAGS);
        rd_chk("flags low", 8'h00);
        rd_chk("flags high", 8'h01);
        rd_chk("flags high", 8'h00);
        chk_bit("int_n", 1'b1, int_n);
        done("dma end");
        // frame interrupt mode: one sof pulse gives a one-cycle interrupt
        int_pin_mode_sof = 1'b1;
        sof_seen = 1'b1;
        step(1);
        sof_seen = 1'b0;
        chk_bit("int_n", 1'b0, int_n);
        step(1);
        chk_bit("int_n", 1'b1, int_n);
        int_pin_mode_sof = 1'b0;
        done("frame interrupt");
        print_verdict();
    end
endmodule
